// ===== rtl/osdft_defs.svh
// constants of the on-screen display frame timing and output block
// Function
// - vertical start: 64 steps of four lines
// - vertical start nonzero, reset default 4
// - horizontal start: 32 steps of five dots
// - horizontal start nonzero, reset default 5
// - display runs only with enable bit 7
// - edge decoration only while bit 6 set
// - bit 5 selects shadow, else border
// - border four sides, shadow right and bottom
// - bit 0 picks blanking: chars only or windows
// - half-tone equals window waveform, windows only
// - colour pins are character OR window colour
// - line start: 47 dots, pulse, plus offset
// - frame start: one line plus offset
// - dot clock is 320 times line rate
// - 240 displayed dots per line unless the line flyback comes first
// - double width shows even columns doubled
// - code 00 blank, code 7F full
// - double height doubles row height
// - window 0 wins overlaps, inverted windows hidden
`ifndef OSDFT_DEFS_SVH
`define OSDFT_DEFS_SVH

// ****************************************************************
// register columns of row 10 and reset values
// ****************************************************************
`define OSDFT_COL_VERT 5'h09
`define OSDFT_COL_HORIZ 5'h0A
`define OSDFT_COL_HEIGHT 5'h0B
`define OSDFT_COL_CTRL 5'h0C
`define OSDFT_VERT_RST 8'h04
`define OSDFT_HORIZ_RST 8'h05
`define OSDFT_HEIGHT_RST 8'h10
`define OSDFT_CTRL_RST 8'h00
`define OSDFT_VERT_FIELD 5:0
`define OSDFT_HORIZ_FIELD 4:0
`define OSDFT_HEIGHT_FIELD 5:0
`define OSDFT_BIT_ENABLE 7
`define OSDFT_BIT_EDGE 6
`define OSDFT_BIT_SHADOW 5
`define OSDFT_BIT_FBMODE 0

// ****************************************************************
// frame timing
// ****************************************************************
`define OSDFT_H_FIXED 10'h02F
`define OSDFT_PHASE_PULSE 10'h004
`define OSDFT_V_FIXED 10'h001
`define OSDFT_DOT_LAST 10'h13F
`define OSDFT_DOT_MAX 10'h3FF
`define OSDFT_DISP_LAST 8'hEF
`define OSDFT_CELL_LAST 5'h09
`define OSDFT_CELL_LAST_DW 5'h13
`define OSDFT_FONT_STEP 8'h10
`define OSDFT_ROW_LAST 4'h9
`define OSDFT_DOT_IDX_LAST 4'h9
`define OSDFT_CODE_BLANK 7'h00
`define OSDFT_CODE_FULL 7'h7F

`endif

// ===== rtl/osdft_pkg.sv
// types shared by the frame timing and output block
package osdft_pkg;
    typedef enum logic [3:0] {
        OSDFT_V_IDLE = 4'h1,
        OSDFT_V_WAIT = 4'h2,
        OSDFT_V_ROWS = 4'h4,
        OSDFT_V_DONE = 4'h8
    } osdft_vstate_t;

    // one background window, bounds in memory rows and columns
    typedef struct packed {
        logic enable;
        logic [3:0] rowStart;
        logic [3:0] rowEnd;
        logic [4:0] colStart;
        logic [4:0] colEnd;
        logic [2:0] rgb;
    } osdft_win_t;

    // font lines around the current one, bit 0 is the leftmost dot
    typedef struct packed {
        logic [9:0] above;
        logic [9:0] cur;
        logic [9:0] below;
    } osdft_font_t;
endpackage : osdft_pkg

// ===== rtl/osdft_frame_timing.sv
// frame timing, font scaling and video output of the display generator
`timescale 1ns/100ps
`include "osdft_defs.svh"
module osdft_frame_timing (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic regWrite,
    input wire logic [4:0] regColumn,
    input wire logic [7:0] regData,
    input wire logic horizontalFlybackInput,
    input wire logic verticalFlybackInput,
    output logic [3:0] charRow,
    output logic [4:0] charColumn,
    input wire logic [6:0] charCode,
    input wire logic [2:0] charRgb,
    input wire logic rowDoubleHeightBit,
    input wire logic rowDoubleWidthBit,
    output logic [3:0] fontLine,
    input osdft_pkg::osdft_font_t fontBits,
    input osdft_pkg::osdft_win_t [2:0] winCfg,
    output logic [2:0] rgbOut,
    output logic fastBlankingOutput,
    output logic halfToneOutput,
    output logic dotLocked
);
    import osdft_pkg::*;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    // ****************************************************************
    // frame control registers
    // ****************************************************************
    logic [7:0] vertReg, next_vertReg;
    logic [7:0] horizReg, next_horizReg;
    logic [7:0] heightReg, next_heightReg;
    logic [7:0] ctrlReg, next_ctrlReg;
    logic [5:0] verticalStartOffset;
    logic [4:0] horizontalStartOffset;
    logic [5:0] characterHeightValue;
    logic displayEnableBit;
    logic edgeDecorationEnable;
    logic shadowSelect;
    logic blankingModeSelect;

    // a zero offset write is dropped so the position can never be zero
    always_comb
    begin
        next_vertReg = vertReg;
        next_horizReg = horizReg;
        next_heightReg = heightReg;
        next_ctrlReg = ctrlReg;
        if (regWrite)
        begin
            case (regColumn)
                `OSDFT_COL_VERT:
                    if (regData[`OSDFT_VERT_FIELD] != 6'h00) next_vertReg = regData;
                `OSDFT_COL_HORIZ:
                    if (regData[`OSDFT_HORIZ_FIELD] != 5'h00) next_horizReg = regData;
                `OSDFT_COL_HEIGHT: next_heightReg = regData;
                `OSDFT_COL_CTRL: next_ctrlReg = regData;
                default: next_ctrlReg = ctrlReg;
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            vertReg <= `OSDFT_VERT_RST;
            horizReg <= `OSDFT_HORIZ_RST;
            heightReg <= `OSDFT_HEIGHT_RST;
            ctrlReg <= `OSDFT_CTRL_RST;
        end
        else
        begin
            vertReg <= next_vertReg;
            horizReg <= next_horizReg;
            heightReg <= next_heightReg;
            ctrlReg <= next_ctrlReg;
        end
    end

    assign verticalStartOffset = vertReg[`OSDFT_VERT_FIELD];
    assign horizontalStartOffset = horizReg[`OSDFT_HORIZ_FIELD];
    assign characterHeightValue = heightReg[`OSDFT_HEIGHT_FIELD];
    assign displayEnableBit = ctrlReg[`OSDFT_BIT_ENABLE];
    assign edgeDecorationEnable = ctrlReg[`OSDFT_BIT_EDGE];
    assign shadowSelect = ctrlReg[`OSDFT_BIT_SHADOW];
    assign blankingModeSelect = ctrlReg[`OSDFT_BIT_FBMODE];

    AST_VERT_DEFAULT: assert property ($past(sys_rst) |-> vertReg == `OSDFT_VERT_RST)
        else $error("vertical start not at default after reset");
    AST_HORIZ_DEFAULT: assert property ($past(sys_rst) |-> horizReg == `OSDFT_HORIZ_RST)
        else $error("horizontal start not at default after reset");
    AST_NO_ZERO_OFFSET: assert property (verticalStartOffset != 6'h00
        && horizontalStartOffset != 5'h00)
        else $error("start offset became zero");

    // ****************************************************************
    // horizontal timing, one core clock per dot
    // ****************************************************************
    logic hfPrev, next_hfPrev;
    logic [9:0] dotCnt, next_dotCnt;
    logic next_dotLocked;
    logic hActive, next_hActive;
    logic [7:0] pixCnt, next_pixCnt;
    logic [4:0] cellCnt, next_cellCnt;
    logic [4:0] dotInCell, next_dotInCell;
    logic rowDw, next_rowDw;
    logic hEdge;
    logic lineGo;
    logic [9:0] hStart;
    logic [4:0] cellLast;

    assign hEdge = horizontalFlybackInput & ~hfPrev;
    assign hStart = `OSDFT_H_FIXED + `OSDFT_PHASE_PULSE
        + {3'h0, horizontalStartOffset, 2'h0} + {5'h00, horizontalStartOffset};
    assign lineGo = (dotCnt == hStart) & ~hEdge;
    assign cellLast = rowDw ? `OSDFT_CELL_LAST_DW : `OSDFT_CELL_LAST;

    always_comb
    begin
        next_hfPrev = horizontalFlybackInput;
        next_dotCnt = (dotCnt == `OSDFT_DOT_MAX) ? dotCnt : dotCnt + 10'h001;
        next_dotLocked = dotLocked;
        next_hActive = hActive;
        next_pixCnt = pixCnt;
        next_cellCnt = cellCnt;
        next_dotInCell = dotInCell;
        if (hEdge)
        begin
            next_dotCnt = 10'h000;
            // lock holds while each line spans exactly 320 dot clocks
            next_dotLocked = (dotCnt == `OSDFT_DOT_LAST);
            next_hActive = 1'b0;
        end
        else if (lineGo)
        begin
            next_hActive = 1'b1;
            next_pixCnt = 8'h00;
            next_cellCnt = 5'h00;
            next_dotInCell = 5'h00;
        end
        else if (hActive)
        begin
            next_pixCnt = pixCnt + 8'h01;
            if (pixCnt == `OSDFT_DISP_LAST) next_hActive = 1'b0;
            if (dotInCell == cellLast)
            begin
                next_dotInCell = 5'h00;
                next_cellCnt = cellCnt + 5'h01;
            end
            else
            begin
                next_dotInCell = dotInCell + 5'h01;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            hfPrev <= 1'b0;
            dotCnt <= 10'h000;
            dotLocked <= 1'b0;
            hActive <= 1'b0;
            pixCnt <= 8'h00;
            cellCnt <= 5'h00;
            dotInCell <= 5'h00;
        end
        else
        begin
            hfPrev <= next_hfPrev;
            dotCnt <= next_dotCnt;
            dotLocked <= next_dotLocked;
            hActive <= next_hActive;
            pixCnt <= next_pixCnt;
            cellCnt <= next_cellCnt;
            dotInCell <= next_dotInCell;
        end
    end

    // on double width rows even memory columns only, each cell spans twenty dots
    assign charColumn = rowDw ? {cellCnt[3:0], 1'b0} : cellCnt;

    AST_H_START: assert property ($rose(hActive) |-> $past(dotCnt) == hStart)
        else $error("display line started at wrong dot");
    AST_DISP_DOTS: assert property ($fell(hActive) && !$past(hEdge)
        |-> $past(pixCnt) == `OSDFT_DISP_LAST)
        else $error("line did not hold 240 dots");
    AST_EVEN_COL: assert property (rowDw |-> !charColumn[0])
        else $error("odd column shown on double width row");
    AST_DOT_LOCK: assert property (hEdge && dotCnt == `OSDFT_DOT_LAST |=> dotLocked)
        else $error("lock not flagged on 320 dot line");

    // ****************************************************************
    // vertical timing and font line scaling
    // ****************************************************************
    osdft_vstate_t vState, next_vState;
    logic vfPrev, next_vfPrev;
    logic [9:0] lineCnt, next_lineCnt;
    logic [3:0] memRow, next_memRow;
    logic [6:0] rowLine, next_rowLine;
    logic [6:0] fontAcc, next_fontAcc;
    logic [3:0] fontLineReg, next_fontLineReg;
    logic rowDh, next_rowDh;
    logic vEdge;
    logic inRows;
    logic [9:0] vStartLine;
    logic [6:0] rowH;
    logic [7:0] accSum;
    logic [7:0] accDiff;

    assign vEdge = verticalFlybackInput & ~vfPrev;
    assign vStartLine = `OSDFT_V_FIXED + {2'h0, verticalStartOffset, 2'h0};
    assign rowH = rowDh ? {characterHeightValue, 1'b0}
        : {1'b0, characterHeightValue};
    assign accSum = {1'b0, fontAcc} + `OSDFT_FONT_STEP;
    assign accDiff = accSum - {1'b0, rowH};
    assign inRows = (vState == OSDFT_V_ROWS);

    always_comb
    begin
        next_vfPrev = verticalFlybackInput;
        next_vState = vState;
        next_lineCnt = lineCnt;
        next_memRow = memRow;
        next_rowLine = rowLine;
        next_fontAcc = fontAcc;
        next_fontLineReg = fontLineReg;
        next_rowDh = rowDh;
        next_rowDw = rowDw;
        // row format is sampled once the row address has settled
        if (lineGo)
        begin
            next_rowDh = rowDoubleHeightBit;
            next_rowDw = rowDoubleWidthBit;
        end
        if (vEdge)
        begin
            next_vState = OSDFT_V_WAIT;
            next_lineCnt = 10'h000;
            next_memRow = 4'h0;
        end
        else if (hEdge)
        begin
            next_lineCnt = lineCnt + 10'h001;
            case (vState)
                OSDFT_V_WAIT:
                    if (lineCnt + 10'h001 == vStartLine)
                    begin
                        next_vState = OSDFT_V_ROWS;
                        next_memRow = 4'h0;
                        next_rowLine = 7'h00;
                        next_fontAcc = 7'h00;
                        next_fontLineReg = 4'h0;
                    end
                OSDFT_V_ROWS:
                begin
                    // step the font line whenever the sum of sixteen per scan line reaches the row height
                    if (accSum >= {1'b0, rowH})
                    begin
                        next_fontAcc = accDiff[6:0];
                        next_fontLineReg = fontLineReg + 4'h1;
                    end
                    else
                    begin
                        next_fontAcc = accSum[6:0];
                    end
                    next_rowLine = rowLine + 7'h01;
                    if (rowLine + 7'h01 >= rowH)
                    begin
                        next_rowLine = 7'h00;
                        next_fontAcc = 7'h00;
                        next_fontLineReg = 4'h0;
                        next_memRow = memRow + 4'h1;
                        // rows past the last are never drawn, even if the frame is long
                        if (memRow == `OSDFT_ROW_LAST) next_vState = OSDFT_V_DONE;
                    end
                end
                OSDFT_V_IDLE: next_vState = OSDFT_V_IDLE;
                OSDFT_V_DONE: next_vState = OSDFT_V_DONE;
                default: next_vState = OSDFT_V_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            vfPrev <= 1'b0;
            vState <= OSDFT_V_IDLE;
            lineCnt <= 10'h000;
            memRow <= 4'h0;
            rowLine <= 7'h00;
            fontAcc <= 7'h00;
            fontLineReg <= 4'h0;
            rowDh <= 1'b0;
            rowDw <= 1'b0;
        end
        else
        begin
            vfPrev <= next_vfPrev;
            vState <= next_vState;
            lineCnt <= next_lineCnt;
            memRow <= next_memRow;
            rowLine <= next_rowLine;
            fontAcc <= next_fontAcc;
            fontLineReg <= next_fontLineReg;
            rowDh <= next_rowDh;
            rowDw <= next_rowDw;
        end
    end

    assign charRow = memRow;
    assign fontLine = fontLineReg;

    AST_V_START: assert property ($rose(inRows) |-> $past(lineCnt) + 10'h001 == vStartLine)
        else $error("frame started on wrong line");
    AST_ROW_HEIGHT: assert property (inRows && $changed(memRow)
        |-> $past(rowLine) + 7'h01 >= $past(rowH))
        else $error("row ended before its height");

    // ****************************************************************
    // dot pattern, decoration, windows and pin drive
    // ****************************************************************
    logic [9:0] fa, fc, fb;
    logic [3:0] dotIdx;
    logic dotLit, leftLit, rightLit, upLit, downLit;
    logic edgeDot, charArea, inDisp;
    logic [2:0] winHit;
    logic winAny;
    logic [2:0] winRgb;
    logic [2:0] next_rgbOut;
    logic next_fastBlank, next_halfTone;

    always_comb
    begin
        fa = fontBits.above;
        fc = fontBits.cur;
        fb = fontBits.below;
        if (charCode == `OSDFT_CODE_BLANK)
        begin
            fa = 10'h000;
            fc = 10'h000;
            fb = 10'h000;
        end
        else if (charCode == `OSDFT_CODE_FULL)
        begin
            fa = 10'h3FF;
            fc = 10'h3FF;
            fb = 10'h3FF;
        end
    end

    assign dotIdx = rowDw ? dotInCell[4:1] : dotInCell[3:0];
    assign dotLit = fc[dotIdx];
    assign leftLit = (dotIdx != 4'h0) && fc[dotIdx - 4'h1];
    assign rightLit = (dotIdx != `OSDFT_DOT_IDX_LAST) && fc[dotIdx + 4'h1];
    assign upLit = fa[dotIdx];
    assign downLit = fb[dotIdx];
    // shadow marks dots right of or below a lit dot; border marks all four
    assign edgeDot = ~dotLit & edgeDecorationEnable & (shadowSelect
        ? (leftLit | upLit) : (leftLit | rightLit | upLit | downLit));
    assign charArea = dotLit | edgeDot;
    assign inDisp = displayEnableBit & hActive & inRows;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : gWin
            assign winHit[gi] = winCfg[gi].enable
                && winCfg[gi].rowStart <= winCfg[gi].rowEnd
                && winCfg[gi].colStart <= winCfg[gi].colEnd
                && memRow >= winCfg[gi].rowStart && memRow <= winCfg[gi].rowEnd
                && charColumn >= winCfg[gi].colStart && charColumn <= winCfg[gi].colEnd;
        end
    endgenerate

    assign winAny = |winHit;
    assign winRgb = winHit[0] ? winCfg[0].rgb
        : winHit[1] ? winCfg[1].rgb
        : winHit[2] ? winCfg[2].rgb : 3'h0;

    always_comb
    begin
        next_rgbOut = 3'h0;
        next_fastBlank = 1'b0;
        next_halfTone = 1'b0;
        if (inDisp)
        begin
            // decoration dots are black, so they add nothing to the colour
            next_rgbOut = (dotLit ? charRgb : 3'h0) | winRgb;
            next_halfTone = winAny;
            next_fastBlank = charArea | (~blankingModeSelect & winAny);
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            rgbOut <= 3'h0;
            fastBlankingOutput <= 1'b0;
            halfToneOutput <= 1'b0;
        end
        else
        begin
            rgbOut <= next_rgbOut;
            fastBlankingOutput <= next_fastBlank;
            halfToneOutput <= next_halfTone;
        end
    end

    AST_DISABLED_DARK: assert property (!displayEnableBit ##1 !displayEnableBit
        |-> rgbOut == 3'h0 && !fastBlankingOutput && !halfToneOutput)
        else $error("output active while display disabled");
    AST_HALFTONE_WIN: assert property (halfToneOutput |-> $past(winAny) && $past(inDisp))
        else $error("half-tone outside window");
    AST_FB_CHARS_ONLY: assert property ($past(blankingModeSelect) && !$past(charArea)
        |-> !fastBlankingOutput)
        else $error("fast blanking high outside character");
    AST_SHADOW_SIDES: assert property (edgeDot && shadowSelect |-> leftLit || upLit)
        else $error("shadow dot not right or below a lit dot");
endmodule : osdft_frame_timing

// ===== tb/osdft_video_partner.sv
// monitor side model: flyback timing, character memory and font supply
`timescale 1ns/100ps
module osdft_video_partner (
    input wire logic core_clk,
    input wire logic [9:0] lineLen,
    input wire logic [6:0] testCode,
    input wire logic wideRows,
    input wire logic [4:0] charColumn,
    output logic horizontalFlybackInput,
    output logic verticalFlybackInput,
    output logic [6:0] charCode,
    output logic [2:0] charRgb,
    output logic rowDoubleHeightBit,
    output logic rowDoubleWidthBit,
    output osdft_pkg::osdft_font_t fontBits
);
    import osdft_pkg::*;
    logic [9:0] dot = 10'h000;
    logic [3:0] line = 4'h0;
    // ****************************************************************
    // flyback timing
    // ****************************************************************
    // 12-line frames keep the run small: later rows are cut, but each
    // measured line ends before the next frame flyback
    always_ff @(posedge core_clk)
    begin
        if (dot >= lineLen - 10'h001)
        begin
            dot <= 10'h000;
            line <= (line == 4'hB) ? 4'h0 : line + 4'h1;
        end
        else
            dot <= dot + 10'h001;
    end
    assign horizontalFlybackInput = dot < 10'h008;
    // frame flyback rises well after the line edge so the two never collide
    assign verticalFlybackInput = line == 4'h0 && dot >= 10'h010 && dot < 10'h020;
    // ****************************************************************
    // character memory and font
    // ****************************************************************
    // odd columns hold the blank code so double width shows what it picks
    assign charCode = charColumn[0] ? 7'h00 : testCode;
    assign charRgb = 3'h1;
    assign rowDoubleHeightBit = wideRows;
    assign rowDoubleWidthBit = wideRows;
    // dots 4,5 lit, dots 6,7 lit on the line below: tells each edge side apart
    assign fontBits = {10'h000, 10'h030, 10'h0C0};
endmodule : osdft_video_partner

// ===== tb/tb_osdft_frame_timing.sv
// self-checking bench of the frame timing and output block
`timescale 1ns/100ps
`include "osdft_defs.svh"
module tb_osdft_frame_timing;
    import osdft_pkg::*;
    typedef struct packed {
        logic [9:0] first;
        logic [8:0] nRgb;
        logic [2:0] rgb;
        logic [8:0] nFb;
        logic [8:0] nHt;
        logic lock;
        logic [7:0] pos;
    } osdft_meas_t;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic regWrite = 1'b0;
    logic [4:0] regColumn = 5'h00;
    logic [7:0] regData = 8'h00;
    logic [9:0] lineLen = 10'h1E0;
    logic [6:0] testCode = 7'h00;
    logic wideRows = 1'b0;
    osdft_win_t [2:0] winCfg = '0;
    logic hFly, vFly, rowDh, rowDw, fastBlank, halfTone, dotLocked;
    logic [3:0] charRow, fontLine;
    logic [4:0] charColumn;
    logic [6:0] charCode;
    logic [2:0] charRgb, rgbOut;
    osdft_font_t fontBits;
    osdft_meas_t notes[$];
    osdft_meas_t got;
    logic busy = 1'b0;
    logic prevH = 1'b0;
    logic [9:0] n;
    int badCount = 0;
    int checksDone = 0;

    osdft_frame_timing i_osdft_frame_timing (.core_clk(core_clk), .sys_rst(sys_rst),
        .regWrite(regWrite), .regColumn(regColumn), .regData(regData),
        .horizontalFlybackInput(hFly), .verticalFlybackInput(vFly), .charRow(charRow),
        .charColumn(charColumn), .charCode(charCode), .charRgb(charRgb),
        .rowDoubleHeightBit(rowDh), .rowDoubleWidthBit(rowDw), .fontLine(fontLine),
        .fontBits(fontBits), .winCfg(winCfg), .rgbOut(rgbOut),
        .fastBlankingOutput(fastBlank), .halfToneOutput(halfTone), .dotLocked(dotLocked));
    osdft_video_partner i_osdft_video_partner (.core_clk(core_clk), .lineLen(lineLen),
        .testCode(testCode), .wideRows(wideRows), .charColumn(charColumn),
        .horizontalFlybackInput(hFly), .verticalFlybackInput(vFly), .charCode(charCode),
        .charRgb(charRgb), .rowDoubleHeightBit(rowDh), .rowDoubleWidthBit(rowDw),
        .fontBits(fontBits));

    initial
    begin
        forever #50 core_clk = ~core_clk;
    end

    task automatic results();
        if (badCount == 0 && checksDone > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : results

    task automatic chk(input logic [9:0] g, input logic [9:0] e);
        checksDone++;
        if (g !== e)
        begin
            badCount++;
            $display("BAD %0t got %0h expected %0h", $time, g, e);
        end
    endtask : chk

    // ****************************************************************
    // watcher: one measured line per note, compared at the next line edge
    // ****************************************************************
    always @(negedge core_clk)
    begin
        if (hFly === 1'b1 && prevH === 1'b0)
        begin
            if (busy)
            begin
                got.lock = dotLocked;
                chk(got.first, notes[0].first);
                chk(10'(got.nRgb), 10'(notes[0].nRgb));
                chk(10'(got.rgb), 10'(notes[0].rgb));
                chk(10'(got.nFb), 10'(notes[0].nFb));
                chk(10'(got.nHt), 10'(notes[0].nHt));
                chk(10'(got.lock), 10'(notes[0].lock));
                chk(10'(got.pos), 10'(notes[0].pos));
                void'(notes.pop_front());
                busy = 1'b0;
            end
            if (notes.size() > 0)
            begin
                busy = 1'b1;
                got = '0;
                n = 10'h000;
            end
        end
        else if (busy)
        begin
            n = n + 10'h001;
            if (got.first == 10'h000 && (rgbOut != 3'h0 || fastBlank === 1'b1
                || halfTone === 1'b1))
            begin
                got.first = n;
                got.pos = {charRow, fontLine};
            end
            if (rgbOut != 3'h0)
                got.nRgb = got.nRgb + 9'h001;
            if (fastBlank === 1'b1)
                got.nFb = got.nFb + 9'h001;
            if (halfTone === 1'b1)
                got.nHt = got.nHt + 9'h001;
            got.rgb = got.rgb | rgbOut;
        end
        prevH = hFly;
    end

    task automatic wr(input logic [4:0] c, input logic [7:0] d);
        @(posedge core_clk);
        regWrite <= 1'b1;
        regColumn <= c;
        regData <= d;
        @(posedge core_clk);
        regWrite <= 1'b0;
    endtask : wr

    // a hang on the flyback lines counts as a mismatch
    task automatic waitRise(input logic useV);
        logic was;
        int i;
        was = useV ? vFly : hFly;
        for (i = 0; i < 8000; i++)
        begin
            @(negedge core_clk);
            if ((useV ? vFly : hFly) === 1'b1 && was === 1'b0)
                return;
            was = useV ? vFly : hFly;
        end
        badCount++;
        results();
    endtask : waitRise

    // ****************************************************************
    // one scenario: configure, then measure the line before and two row lines
    // ****************************************************************
    task automatic run(input logic [7:0] ctrl, input logic [6:0] code, input logic wide,
        input logic [1:0] win, input logic [9:0] len, input logic [3:0] dot,
        input logic [8:0] nR, input logic [2:0] rgb, input logic [8:0] nF,
        input logic [8:0] nH);
        logic [7:0] h;
        logic [7:0] v;
        logic [2:0] wc;
        osdft_meas_t e;
        h = 8'h01 + 8'($urandom % ((len == 10'h140) ? 5 : 21));
        v = 8'h01 + 8'($urandom % 2);
        wc = 3'h1 + 3'($urandom % 6);
        @(posedge core_clk);
        winCfg[0] <= {win == 2'h1 || win == 2'h2, 4'h0, 4'h9, 5'h00, 5'h1F, wc};
        winCfg[1] <= {win == 2'h2, 4'h0, 4'h9, 5'h00, 5'h1F, ~wc};
        winCfg[2] <= {win == 2'h3, 4'h9, 4'h0, 5'h00, 5'h1F, 3'h7};
        lineLen <= len;
        testCode <= code;
        wideRows <= wide;
        wr(`OSDFT_COL_HORIZ, h);
        wr(`OSDFT_COL_HORIZ, 8'hE0);
        wr(`OSDFT_COL_VERT, v);
        wr(`OSDFT_COL_VERT, 8'hC0);
        wr(`OSDFT_COL_HEIGHT, 8'h10);
        wr(`OSDFT_COL_CTRL, ctrl);
        e = '0;
        e.lock = len == 10'h140;
        waitRise(1'b1);
        repeat (4 * v - 1) waitRise(1'b0);
        @(posedge core_clk);
        notes.push_back(e);
        if ((nR | nF | nH) != 9'h000)
        begin
            e.first = 10'h036 + 10'(h) * 10'h005 + 10'(dot);
            e.nRgb = nR;
            e.rgb = rgb | ((win == 2'h1 || win == 2'h2) ? wc : 3'h0);
            e.nFb = nF;
            e.nHt = nH;
        end
        waitRise(1'b0);
        @(posedge core_clk);
        notes.push_back(e);
        waitRise(1'b0);
        @(posedge core_clk);
        // second row line: one font line per scan line, half that when doubled
        if (e.first != 10'h000) e.pos = {7'h00, !wide};
        notes.push_back(e);
        waitRise(1'b0);
        waitRise(1'b0);
    endtask : run

    initial
    begin
        void'($urandom(32'hE0BFFE5E));
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        run(8'h80, 7'h7F, 1'b0, 2'h0, 10'h140, 4'h0, 9'h078, 3'h1, 9'h078, 9'h000);
        run(8'h00, 7'h7F, 1'b0, 2'h1, 10'h1E0, 4'h0, 9'h000, 3'h0, 9'h000, 9'h000);
        run(8'h80, 7'h00, 1'b0, 2'h1, 10'h1E0, 4'h0, 9'h0F0, 3'h0, 9'h0F0, 9'h0F0);
        run(8'h81, 7'h00, 1'b0, 2'h1, 10'h1E0, 4'h0, 9'h0F0, 3'h0, 9'h000, 9'h0F0);
        run(8'h81, 7'h7F, 1'b0, 2'h1, 10'h1E0, 4'h0, 9'h0F0, 3'h1, 9'h078, 9'h0F0);
        run(8'h80, 7'h00, 1'b0, 2'h2, 10'h1E0, 4'h0, 9'h0F0, 3'h0, 9'h0F0, 9'h0F0);
        run(8'h80, 7'h00, 1'b0, 2'h3, 10'h1E0, 4'h0, 9'h000, 3'h0, 9'h000, 9'h000);
        run(8'h80, 7'h7F, 1'b1, 2'h0, 10'h1E0, 4'h0, 9'h0F0, 3'h1, 9'h0F0, 9'h000);
        run(8'h80, 7'h41, 1'b0, 2'h0, 10'h1E0, 4'h4, 9'h018, 3'h1, 9'h018, 9'h000);
        run(8'hC0, 7'h41, 1'b0, 2'h0, 10'h1E0, 4'h3, 9'h018, 3'h1, 9'h03C, 9'h000);
        run(8'hE0, 7'h41, 1'b0, 2'h0, 10'h1E0, 4'h4, 9'h018, 3'h1, 9'h024, 9'h000);
        // let the watcher finish the last line before the verdict
        @(posedge core_clk);
        results();
    end
endmodule : tb_osdft_frame_timing
